/* wdsc_pkg.sv */
// watchdog and sleep control: shared constants and carrier types
// assumes a single 125 MHz clock and an apb register port
package wdsc_pkg;
   // -----------------------------------------------------------
   // register map (byte addresses)
   // -----------------------------------------------------------
   localparam logic [11:0] WDSC_OFS_CTRL  = 12'h000; // control
   localparam logic [11:0] WDSC_OFS_CAUSE = 12'h004; // reset cause
   localparam logic [11:0] WDSC_OFS_CFG   = 12'h008; // config byte
   // -----------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------
   localparam int         WDSC_CFG_EN_BIT  = 0;
   localparam int         WDSC_CFG_PS_LSB  = 1;
   localparam int         WDSC_CTRL_EN_BIT = 0;
   localparam int         WDSC_CAUSE_PD    = 3;
   localparam int         WDSC_CAUSE_TO    = 4;
   localparam logic [7:0] WDSC_CTRL_RST    = 8'h00;
   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int WDSC_CLK_MHZ   = 125;
   localparam int WDSC_OST_TOSC  = 1024;  // start-up, osc periods
   localparam int WDSC_TOSC_CYC  = 1;     // clocks per osc period
   localparam int WDSC_OST_CYC   = WDSC_OST_TOSC * WDSC_TOSC_CYC;
   localparam int WDSC_RC_DIV    = 16;    // clocks per rc tick
   localparam int WDSC_WDT_BASE  = 64;    // rc ticks per base period
   localparam int WDSC_PC_W      = 21;
   localparam int WDSC_PORT_W    = 8;
   localparam int WDSC_IRQ_W     = 8;
   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef enum logic [1:0]
   {
      WDSC_RUN   = 2'b00,
      WDSC_SLEEP = 2'b01,
      WDSC_OST   = 2'b10
   } wdsc_state_e;

   typedef struct packed
   {
      logic [WDSC_PORT_W-1:0] dout;
      logic [WDSC_PORT_W-1:0] oe_n;
   } wdsc_port_s;

   typedef struct packed
   {
      logic [WDSC_IRQ_W-1:0] flag;
      logic [WDSC_IRQ_W-1:0] enable;
      logic [WDSC_IRQ_W-1:0] sleep_ok;
   } wdsc_irq_s;
endpackage : wdsc_pkg

/* wdsc_top.sv */
// watchdog timer, postscaler and sleep / wake control
// assumes core strobes are one-cycle pulses on clock_i
//
// Functional notes
// - watchdog ticks from its own free divider
// - expiry while running resets the device
// - expiry while asleep wakes the device
// - every expiry clears watchdog expired flag
// - config enable forces watchdog permanently on
// - else software enable bit runs watchdog
// - clear or sleep clears counter and postscaler
// - clear keeps postscaler ratio selection
// - four bit config field sets postscale ratio
// - sleep clears watchdog and pd_n, sets to_n, stops oscillator
// - port pins hold state during sleep
// - wake on master clear, expiry, interrupt
// - only sleep capable interrupts may wake
// - master clear wake resets, others continue
// - powerdown flag set at power-up, cleared sleeping
// - sleep prefetches instruction at pc plus two
// - enabled interrupt wakes regardless of global enable
// - global enable: next instruction then vector
// - pending interrupt turns sleep into no-op
// - interrupt during sleep wakes after completion
// - crystal modes wait start-up delay on expiry or interrupt wake
// - control register upper bits read zero
module wdsc_top
   import wdsc_pkg::*;
#(
   parameter int RC_DIV   = wdsc_pkg::WDSC_RC_DIV,
   parameter int WDT_BASE = wdsc_pkg::WDSC_WDT_BASE
)
(
   input  wire logic                           clock_i,
   input  wire logic                           sys_rst_i,
   // apb slave
   input  wire logic                           psel_i,
   input  wire logic                           penable_i,
   input  wire logic                           pwrite_i,
   input  wire logic [11:0]                    paddr_i,
   input  wire logic [31:0]                    pwdata_i,
   output logic      [31:0]                    prdata_o,
   output logic                                pready_o,
   output logic                                pslverr_o,
   // configuration and core
   input  wire logic [7:0]                     wdt_config_byte_i,
   input  wire logic                           clear_watchdog_instr_i,
   input  wire logic                           sleep_instr_i,
   input  wire logic                           instr_retire_i,
   input  wire logic [wdsc_pkg::WDSC_PC_W-1:0] pc_i,
   input  wire logic                           global_irq_enable_i,
   input  wire wdsc_pkg::wdsc_irq_s            irq_i,
   input  wire logic                           master_clear_pin_n_i,
   input  wire logic                           osc_crystal_mode_i,
   input  wire wdsc_pkg::wdsc_port_s           port_i,
   // outputs
   output wdsc_pkg::wdsc_port_s                port_o,
   output logic [wdsc_pkg::WDSC_PC_W-1:0]      prefetch_addr_o,
   output logic                                device_reset_o,
   output logic                                wdt_reset_o,
   output logic                                core_run_o,
   output logic                                osc_driver_off_o,
   output logic                                branch_vector_o
);
   import wdsc_pkg::*;

   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   localparam int RCW = $clog2(RC_DIV);
   localparam int BW  = $clog2(WDT_BASE);
   localparam int OW  = $clog2(WDSC_OST_CYC);

   wdsc_state_e   state;
   wdsc_state_e   next_state;
   logic [RCW-1:0] rc_cnt;
   logic [BW-1:0]  base_cnt;
   logic [15:0]    ps_cnt;
   logic [OW-1:0]  ost_cnt;
   logic           sw_en;
   logic           to_n;
   logic           pd_n;
   logic           vec_pend;
   wdsc_port_s     port_hold;

   wire  [3:0] ps_sel = wdt_config_byte_i[WDSC_CFG_PS_LSB +: 4];
   wire        rc_tick;
   wire        wdt_on;
   wire        wdt_clr;
   wire        expire;
   wire        irq_pend;
   wire        irq_wake;
   wire        sleep_exec;
   wire        sleep_nop;
   wire        master_clear_pin;
   wire        wake;
   wire        apb_acc;
   wire        apb_wr;
   wire        map_hit;

   // -----------------------------------------------------------
   // functions
   // -----------------------------------------------------------
   // postscale terminal count for a select code
   function automatic logic [15:0] ps_last(input logic [3:0] sel);
      ps_last = 16'(({16'h0000, 16'h0001} << sel) - 32'h1);
   endfunction : ps_last

   // -----------------------------------------------------------
   // decode
   // -----------------------------------------------------------
   // rc time base runs free, never gated by sleep
   assign rc_tick  = (rc_cnt == RCW'(RC_DIV - 1));
   // enable: config bit overrides software
   assign wdt_on   = wdt_config_byte_i[WDSC_CFG_EN_BIT] | sw_en;
   // interrupt sources allowed to wake
   assign irq_pend = |(irq_i.flag & irq_i.enable);
   assign irq_wake = |(irq_i.flag & irq_i.enable & irq_i.sleep_ok);
   assign sleep_exec = sleep_instr_i & (state == WDSC_RUN)
                     & ~irq_pend & ~master_clear_pin;
   assign sleep_nop  = sleep_instr_i & (state == WDSC_RUN)
                     & irq_pend;
   assign wdt_clr  = (clear_watchdog_instr_i & (state == WDSC_RUN))
                   | sleep_exec | ~wdt_on;
   assign expire   = wdt_on & ~wdt_clr & rc_tick
                   & (base_cnt == BW'(WDT_BASE - 1))
                   & (ps_cnt == ps_last(ps_sel));
   assign master_clear_pin     = ~master_clear_pin_n_i;
   assign wake     = (state == WDSC_SLEEP)
                   & (expire | irq_wake);

   // -----------------------------------------------------------
   // rc divider and watchdog counters
   // -----------------------------------------------------------
   // divider is a free oscillator stand-in
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         rc_cnt <= '0;
      else
         rc_cnt <= rc_tick ? '0 : rc_cnt + 1'b1;
   end

   // base counter and postscaler, cleared together
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i || master_clear_pin || wdt_clr || expire)
      begin
         base_cnt <= '0;
         ps_cnt   <= '0;
      end
      else if (rc_tick)
      begin
         if (base_cnt == BW'(WDT_BASE - 1))
         begin
            base_cnt <= '0;
            ps_cnt   <= ps_cnt + 16'h0001;
         end
         else
            base_cnt <= base_cnt + 1'b1;
      end
   end

   // -----------------------------------------------------------
   // sleep state machine
   // -----------------------------------------------------------
   // next state; master clear always lands in run
   always_comb
   begin
      next_state = state;
      unique case (state)
         WDSC_RUN:
            if (sleep_exec)
               next_state = WDSC_SLEEP;
         WDSC_SLEEP:
            if (master_clear_pin)
               next_state = WDSC_RUN;
            else if (wake && osc_crystal_mode_i)
               next_state = WDSC_OST;
            else if (wake)
               next_state = WDSC_RUN;
         WDSC_OST:
            if (master_clear_pin || ost_cnt == OW'(WDSC_OST_CYC - 1))
               next_state = WDSC_RUN;
         default:
            next_state = WDSC_RUN;
      endcase
   end

   // state register and start-up counter
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         state   <= WDSC_RUN;
         ost_cnt <= '0;
      end
      else
      begin
         state   <= next_state;
         ost_cnt <= (state == WDSC_OST) ? ost_cnt + 1'b1 : '0;
      end
   end

   // -----------------------------------------------------------
   // status flags and software enable
   // -----------------------------------------------------------
   // expiry clear wins over the sleep set of to_n
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         to_n <= 1'b1;
         pd_n <= 1'b1;
      end
      else
      begin
         if (expire)
            to_n <= 1'b0;
         else if (sleep_exec)
            to_n <= 1'b1;
         if (sleep_exec)
            pd_n <= 1'b0;
      end
   end

   // software enable; device resets return it to zero
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i || master_clear_pin || (expire && state == WDSC_RUN))
         sw_en <= WDSC_CTRL_RST[WDSC_CTRL_EN_BIT];
      else if (apb_wr && paddr_i == WDSC_OFS_CTRL)
         sw_en <= pwdata_i[WDSC_CTRL_EN_BIT];
   end

   // -----------------------------------------------------------
   // reset and wake outputs
   // -----------------------------------------------------------
   // one-cycle watchdog reset pulse; device reset stays high as long as master clear is held
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         wdt_reset_o    <= 1'b0;
         device_reset_o <= 1'b0;
      end
      else
      begin
         wdt_reset_o    <= expire & (state == WDSC_RUN);
         device_reset_o <= master_clear_pin | (expire & (state == WDSC_RUN));
      end
   end

   // vector after the next retired instruction
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i || master_clear_pin)
      begin
         vec_pend        <= 1'b0;
         branch_vector_o <= 1'b0;
      end
      else
      begin
         branch_vector_o <= vec_pend & instr_retire_i;
         if (wake && irq_wake && global_irq_enable_i)
            vec_pend <= 1'b1;
         else if (instr_retire_i)
            vec_pend <= 1'b0;
      end
   end

   // prefetch address captured as sleep executes
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         prefetch_addr_o <= '0;
      else if (sleep_instr_i && state == WDSC_RUN)
         prefetch_addr_o <= pc_i + WDSC_PC_W'(2);
   end

   assign core_run_o       = (state == WDSC_RUN);
   assign osc_driver_off_o = (state == WDSC_SLEEP);

   // -----------------------------------------------------------
   // port hold during sleep
   // -----------------------------------------------------------
   // track pins through the sleep cycle, then freeze
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         port_hold <= '{dout: '0, oe_n: '1};
         port_o    <= '{dout: '0, oe_n: '1};
      end
      else
      begin
         if (state == WDSC_RUN)
            port_hold <= port_i;
         port_o <= (state == WDSC_RUN) ? port_i : port_hold;
      end
   end

   // -----------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------
   // zero wait state, error on unmapped address
   assign apb_acc   = psel_i & penable_i;
   assign map_hit   = (paddr_i == WDSC_OFS_CTRL)
                    | (paddr_i == WDSC_OFS_CAUSE)
                    | (paddr_i == WDSC_OFS_CFG);
   assign apb_wr    = apb_acc & pwrite_i & map_hit;
   assign pready_o  = 1'b1;
   assign pslverr_o = apb_acc & ~map_hit;

   // read mux; unused bits read as zero
   always_comb
   begin
      prdata_o = 32'h0000_0000;
      if (paddr_i == WDSC_OFS_CTRL)
         prdata_o[WDSC_CTRL_EN_BIT] = sw_en;
      else if (paddr_i == WDSC_OFS_CAUSE)
      begin
         prdata_o[WDSC_CAUSE_TO] = to_n;
         prdata_o[WDSC_CAUSE_PD] = pd_n;
      end
      else if (paddr_i == WDSC_OFS_CFG)
         prdata_o[7:0] = wdt_config_byte_i;
   end

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_sleep_go;
      sleep_instr_i && state == WDSC_RUN && !irq_pend && !master_clear_pin;
   endsequence

   sequence s_asleep;
      state == WDSC_SLEEP && pd_n == 1'b0 && to_n == 1'b1;
   endsequence

   a_expiry_resets: assert property
      (expire && state == WDSC_RUN |=> wdt_reset_o && device_reset_o)
      else $error("run expiry gave no reset");
   a_expiry_wakes: assert property
      (expire && state == WDSC_SLEEP && !master_clear_pin
       |=> state != WDSC_SLEEP && !wdt_reset_o)
      else $error("sleep expiry did not wake");
   a_expiry_flag: assert property
      (expire |=> !to_n)
      else $error("expiry left flag set");
   a_config_forced: assert property
      (wdt_config_byte_i[WDSC_CFG_EN_BIT] && !clear_watchdog_instr_i
       && !sleep_instr_i && !expire && !master_clear_pin && rc_tick
       && base_cnt != BW'(WDT_BASE - 1)
       |=> base_cnt == $past(base_cnt) + 1'b1)
      else $error("config enable ignored");
   a_sleep_entry: assert property
      (s_sleep_go |=> s_asleep ##0 osc_driver_off_o
       && ps_cnt == 16'h0000)
      else $error("sleep entry incomplete");
   a_sleep_nop: assert property
      (sleep_nop && !expire |=> state == WDSC_RUN && $stable(pd_n))
      else $error("pending irq did not cancel sleep");
   a_irq_wake: assert property
      (state == WDSC_SLEEP && irq_wake && !master_clear_pin |=> state != WDSC_SLEEP)
      else $error("interrupt did not wake");
   a_ost_wait: assert property
      ($rose(state == WDSC_OST) |-> (state == WDSC_OST)[*8])
      else $error("start-up wait cut short");
   a_prefetch_pc: assert property
      (sleep_instr_i && state == WDSC_RUN
       |=> prefetch_addr_o == $past(pc_i) + WDSC_PC_W'(2))
      else $error("prefetch address wrong");
   a_port_frozen: assert property
      (state == WDSC_SLEEP && $past(state) == WDSC_SLEEP
       |-> $stable(port_o))
      else $error("port changed while asleep");
   a_master_clear_pin_reset: assert property
      (master_clear_pin |=> device_reset_o && state == WDSC_RUN)
      else $error("master clear gave no reset");
endmodule : wdsc_top

/* wdsc_top_bench.sv */
// self-checking bench for the watchdog and sleep control block
// assumes wdsc_pkg and wdsc_top are compiled before this file
module wdsc_top_bench
   import wdsc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   localparam int RCD = 2;
   localparam int BAS = 4;
   logic                 clk = 1'b0;
   logic                 rst, psel, pen, pwr, clrw, slp, ret, global_irq_enable;
   logic                 master_clear_pin_n, xtal, pready, perr, er, hit_w;
   logic                 drst, wrst, run, osc_off, bvec;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd, r;
   logic [7:0]           cfg;
   logic [WDSC_PC_W-1:0] pc, pf;
   wdsc_irq_s            irq;
   wdsc_port_s           pin, pout, p0;
   int                   bad_count = 0;
   int                   tests_run = 0;
   int                   seed = 79;
   int                   cyc = 0;
   int                   n;

   wdsc_top #(.RC_DIV(RCD), .WDT_BASE(BAS)) uut
   (
      .clock_i(clk), .sys_rst_i(rst), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .wdt_config_byte_i(cfg),
      .clear_watchdog_instr_i(clrw), .sleep_instr_i(slp),
      .instr_retire_i(ret), .pc_i(pc), .global_irq_enable_i(global_irq_enable),
      .irq_i(irq), .master_clear_pin_n_i(master_clear_pin_n),
      .osc_crystal_mode_i(xtal), .port_i(pin), .port_o(pout),
      .prefetch_addr_o(pf), .device_reset_o(drst),
      .wdt_reset_o(wrst), .core_run_o(run),
      .osc_driver_off_o(osc_off), .branch_vector_o(bvec)
   );
   // ----------------------------------------------------------
   // clock, hang limit and helpers
   // ----------------------------------------------------------
   always #4 clk = ~clk;

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (bad_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // expiry interval in clocks for a postscale code
   function automatic int expiry(input int s);
      return RCD * BAS * (1 << s);
   endfunction : expiry

   // one apb transfer, result left in rd and er
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
   endtask : apb

   function automatic logic sig(input int k);
      case (k)
         0: return run;
         1: return drst;
         default: return bvec;
      endcase
   endfunction : sig

   // wait for a design output, noting any watchdog reset seen
   task automatic wait_for(input int k, input int lim);
      n = 0;
      hit_w = 1'b0;
      while (sig(k) !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
         hit_w |= (wrst === 1'b1);
      end
   endtask : wait_for

   task automatic do_sleep;
      r = $random(seed);
      pc  <= r[WDSC_PC_W-1:0];
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      @(posedge clk);
      check("prefetch", pf, 21'(pc + 21'h2));
   endtask : do_sleep
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      {rst, psel, pen, pwr, clrw, slp, ret, global_irq_enable, xtal} = 9'h1FF;
      {psel, pen, pwr, clrw, slp, ret, global_irq_enable, xtal} = 8'h00;
      master_clear_pin_n = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      cfg = 8'h00;
      pc = '0;
      irq = '0;
      pin = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // register reset values, masking and refusal
      apb(1'b0, WDSC_OFS_CTRL, 32'h0);
      check("control reset", rd, 32'h0);
      apb(1'b0, WDSC_OFS_CAUSE, 32'h0);
      check("cause flags", rd[4:3], 2'b11);
      apb(1'b0, 12'h00C, 32'h0);
      check("unmapped error", er, 1'b1);
      r = $random(seed);
      apb(1'b1, WDSC_OFS_CTRL, r);
      apb(1'b0, WDSC_OFS_CTRL, 32'h0);
      check("control readback", rd, {31'h0, r[0]});
      apb(1'b1, WDSC_OFS_CTRL, 32'h0);
      // pending interrupt makes sleep a no-op
      irq <= '{8'h01, 8'h01, 8'h01};
      do_sleep();
      check("no-op sleep run", run, 1'b1);
      irq <= '0;
      apb(1'b0, WDSC_OFS_CAUSE, 32'h0);
      check("no-op sleep flags", rd[4:3], 2'b11);
      // watchdog off when both enables are clear
      wait_for(1, 100);
      check("disabled watchdog", hit_w, 1'b0);
      // forced enable, postscale codes, clear restarts count
      for (int s = 0; s < 3; s++)
      begin
         cfg  <= {3'h0, 4'(s), 1'b1};
         clrw <= 1'b1;
         @(posedge clk);
         clrw <= 1'b0;
         wait_for(1, 400);
         check("watchdog reset", wrst, 1'b1);
         check("expiry early", n >= expiry(s) - RCD, 1'b1);
         check("expiry late", n <= expiry(s) + RCD + 4, 1'b1);
      end
      // clears every five cycles keep the forced watchdog quiet
      hit_w = 1'b0;
      cfg <= 8'h01;
      for (int i = 0; i < 60; i++)
      begin
         clrw <= (i % 5 == 0);
         @(posedge clk);
         hit_w |= (wrst === 1'b1);
      end
      clrw <= 1'b0;
      check("cleared watchdog", hit_w, 1'b0);
      cfg <= 8'h00;
      apb(1'b0, WDSC_OFS_CAUSE, 32'h0);
      check("expired flag", rd[4], 1'b0);
      // sleep with software enable, woken by expiry
      apb(1'b1, WDSC_OFS_CTRL, 32'h1);
      r = $random(seed);
      p0 = r[15:0];
      pin <= p0;
      do_sleep();
      check("sleep run", run, 1'b0);
      check("osc driver off", osc_off, 1'b1);
      pin <= ~p0;
      repeat (2) @(posedge clk);
      check("port hold", pout, p0);
      wait_for(0, 60);
      check("expiry wake", run, 1'b1);
      check("no reset on wake", hit_w, 1'b0);
      apb(1'b1, WDSC_OFS_CTRL, 32'h0);
      apb(1'b0, WDSC_OFS_CAUSE, 32'h0);
      check("wake flags", rd[4:3], 2'b00);
      // interrupt wake needs enable and sleep capability
      do_sleep();
      irq <= '{8'h01, 8'h00, 8'h01};
      wait_for(0, 20);
      check("disabled irq", run, 1'b0);
      irq <= '{8'h01, 8'h01, 8'h00};
      wait_for(0, 20);
      check("clocked irq", run, 1'b0);
      irq <= '{8'h01, 8'h01, 8'h01};
      wait_for(0, 4);
      check("irq wake", run, 1'b1);
      irq <= '0;
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      wait_for(2, 4);
      check("no vector", bvec, 1'b0);
      apb(1'b0, WDSC_OFS_CAUSE, 32'h0);
      check("sleep flags", rd[4:3], 2'b10);
      // crystal start-up then vector with global enable
      global_irq_enable  <= 1'b1;
      xtal <= 1'b1;
      do_sleep();
      irq <= '{8'h80, 8'h80, 8'h80};
      wait_for(0, 1200);
      check("start-up short", n >= WDSC_OST_CYC, 1'b1);
      check("start-up long", n <= WDSC_OST_CYC + 8, 1'b1);
      irq <= '0;
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      wait_for(2, 4);
      check("vector", bvec, 1'b1);
      global_irq_enable  <= 1'b0;
      xtal <= 1'b0;
      // master clear while asleep resets the device
      do_sleep();
      master_clear_pin_n <= 1'b0;
      @(posedge clk);
      master_clear_pin_n <= 1'b1;
      wait_for(1, 4);
      check("master clear reset", drst, 1'b1);
      wait_for(0, 6);
      check("run after clear", run, 1'b1);
      print_verdict();
   end
endmodule : wdsc_top_bench
